/* bench/gpr_and_segment_register_file_test.sv */
// testbench: gpr table and segment hand tests
`timescale 1ns/1ps
`default_nettype none
module gpr_and_segment_register_file_test;
	import regfile_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic ref_clk, resetn, c_wr, seg_wr_en, ctl_transfer, stack_op;
	logic [3:0] c_f, c_code;
	logic [63:0] c_data, desc_base, agen_offset, instr_pointer;
	cpu_mode_t mode;
	seg_t seg_wr_sel, agen_seg;
	logic [15:0] seg_wr_data, fetch_sel, agen_sel;
	logic [31:0] desc_limit;
	wire logic ext_prefix, size_override, byte_op, word_op, wr_en;
	wire logic [3:0] wr_code, rd_code_a, rd_code_b;
	wire logic [63:0] wr_data;
	logic [63:0] rd_data_a, rd_data_b, lin_addr, fetch_offset;
	logic byte_conflict, prefix_fault, seg_load_fault, limit_fault;
	int fails, cmp_count;
	// one row: size flags, write code, data, read code, full expected value
	typedef struct packed {
		logic [3:0] f; logic [3:0] wc; logic [63:0] d;
		logic [3:0] rc; logic [63:0] e;
	} row_t;
	row_t rows [8] = '{
		{4'hc, 4'h1, 64'h1111_2222_3333_4444, 4'h1, 64'h1111_2222_3333_4444},
		{4'ha, 4'h1, 64'h0000_0000_0000_00aa, 4'h1, 64'h1111_2222_3333_44aa},
		{4'h9, 4'h1, 64'h0000_0000_0000_bbcc, 4'h1, 64'h1111_2222_3333_bbcc},
		{4'h2, 4'h5, 64'h0000_0000_0000_00dd, 4'h1, 64'h1111_2222_3333_ddcc},
		{4'h0, 4'h1, 64'hffff_ffff_1234_5678, 4'h1, 64'h0000_0000_1234_5678},
		{4'hc, 4'h9, 64'h9999_8888_7777_6666, 4'h9, 64'h9999_8888_7777_6666},
		{4'ha, 4'h5, 64'h0000_0000_0000_00ee, 4'h5, 64'h0000_0000_0000_00ee},
		{4'h2, 4'h1, 64'h0000_0000_0000_0011, 4'h1, 64'h0000_0000_1234_5611}};
	// ------------------------------------------------------------
	// design and partner
	// ------------------------------------------------------------
	pipe_model pm (.ref_clk(ref_clk), .resetn(resetn), .c_f(c_f),
		.c_wr(c_wr), .c_code(c_code), .c_data(c_data), .ext_prefix(ext_prefix),
		.size_override(size_override), .byte_op(byte_op), .word_op(word_op),
		.wr_en(wr_en), .wr_code(wr_code), .wr_data(wr_data),
		.rd_code_a(rd_code_a), .rd_code_b(rd_code_b));
	gpr_seg_regfile dut (.*);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// command lands at the partner one edge later
	task automatic cmd(input logic [3:0] f, input logic w, input logic [3:0] c,
		input logic [63:0] d);
		@(posedge ref_clk);
		{c_f, c_wr, c_code, c_data} <= {f, w, c, d};
	endtask
	task automatic rd(input logic [3:0] c);
		cmd(4'hc, 1'b0, c, 64'h0);
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic sg(input seg_t s, input logic [15:0] d, input logic ct,
		input logic flt);
		@(posedge ref_clk);
		{seg_wr_en, seg_wr_data, ctl_transfer} <= {1'b1, d, ct};
		seg_wr_sel <= s;
		@(negedge ref_clk);
		chk({63'h0, seg_load_fault}, {63'h0, flt});
		@(posedge ref_clk);
		seg_wr_en <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ------------------------------------------------------------
	// clock, watchdog, sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// the whole run needs under a hundred cycles
	initial begin
		#40000;
		fails++;
		summarize();
	end
	initial begin
		{resetn, c_f, c_wr, c_code, c_data, seg_wr_en, ctl_transfer} = '0;
		{stack_op, seg_wr_data, desc_base, agen_offset} = '0;
		mode = MODE_LONG;
		seg_wr_sel = SEG_EXTRA;
		agen_seg = SEG_STACK;
		desc_limit = 32'hffff_ffff;
		instr_pointer = 64'h0000_0000_0000_1234;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(4'h0);
		chk(rd_data_a, 64'h0);
		chk({32'h0, fetch_sel, agen_sel}, 64'h0);
		chk(fetch_offset, 64'h0000_0000_0000_1234);
		foreach (rows[i]) begin
			cmd(rows[i].f, 1'b1, rows[i].wc, rows[i].d);
			rd(rows[i].rc);
			chk(rd_data_a, rows[i].e);
			chk(rd_data_b, rows[i].e);
			chk({62'h0, byte_conflict, prefix_fault}, 64'h0);
		end
		@(posedge ref_clk);
		mode <= MODE_COMPAT;
		@(posedge ref_clk);
		mode <= MODE_LONG;
		rd(4'h9);
		chk({32'h0, rd_data_a[31:0]}, 64'h7777_6666);
		@(posedge ref_clk);
		mode <= MODE_COMPAT;
		@(posedge ref_clk);
		mode <= MODE_LEGACY;
		@(posedge ref_clk);
		mode <= MODE_COMPAT;
		@(posedge ref_clk);
		mode <= MODE_LONG;
		rd(4'h9);
		chk(rd_data_a, 64'h0);
		cmd(4'h2, 1'b0, 4'hc, 64'h0);
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk({63'h0, byte_conflict}, 64'h1);
		chk({63'h0, prefix_fault}, 64'h1);
		sg(SEG_CODE, 16'h0008, 1'b0, 1'b1);
		chk({48'h0, fetch_sel}, 64'h0);
		sg(SEG_CODE, 16'h0008, 1'b1, 1'b0);
		chk({48'h0, fetch_sel}, 64'h8);
		sg(SEG_STACK, 16'h0000, 1'b0, 1'b1);
		for (int i = 0; i < 6; i++) begin
			if (i != 1)
				sg(seg_t'(i[2:0]), {13'h0020, i[2:0]}, 1'b0, 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			agen_seg <= seg_t'(i[2:0]);
			@(negedge ref_clk);
			chk({48'h0, agen_sel}, (i == 1) ? 64'h8 : {61'h20, i[2:0]});
		end
		@(posedge ref_clk);
		agen_seg <= SEG_DATA;
		stack_op <= 1'b1;
		@(negedge ref_clk);
		chk({48'h0, agen_sel}, 64'h0102);
		@(posedge ref_clk);
		{stack_op, desc_base, agen_offset} <= {1'b0, 64'h1000, 64'h20};
		agen_seg <= SEG_AUX1;
		@(negedge ref_clk);
		chk(lin_addr, 64'h1020);
		@(posedge ref_clk);
		agen_seg <= SEG_DATA;
		@(negedge ref_clk);
		chk(lin_addr, 64'h20);
		@(posedge ref_clk);
		desc_limit <= 32'h10;
		mode <= MODE_COMPAT;
		@(negedge ref_clk);
		chk({63'h0, limit_fault}, 64'h1);
		@(posedge ref_clk);
		mode <= MODE_LONG;
		@(negedge ref_clk);
		chk({63'h0, limit_fault}, 64'h0);
		summarize();
	end
endmodule
`default_nettype wire

/* bench/gpr_seg_regfile_sva.sv */
// checker: port timing relations of the register file
`timescale 1ns/1ps
`default_nettype none
module gpr_seg_regfile_sva
	import regfile_pkg::*;
(
	input wire logic                   ref_clk,        // core clock
	input wire logic                   resetn,         // async reset, low
	input wire regfile_pkg::cpu_mode_t mode,           // operating mode
	input wire logic                   ext_prefix,     // extension prefix
	input wire logic                   size_override,  // qword request
	input wire logic                   byte_op,        // byte size
	input wire logic                   word_op,        // word size
	input wire logic [3:0]             rd_code_a,      // read code a
	input wire logic                   wr_en,          // write request
	input wire logic [3:0]             wr_code,        // write code
	input wire logic [GPR_W-1:0]       wr_data,        // write data
	input wire logic                   seg_wr_en,      // selector load
	input wire regfile_pkg::seg_t      seg_wr_sel,     // segment loaded
	input wire logic [SEL_W-1:0]       seg_wr_data,    // selector value
	input wire logic                   ctl_transfer,   // implicit load
	input wire logic [BASE_W-1:0]      desc_base,      // descriptor base
	input wire regfile_pkg::seg_t      agen_seg,       // access segment
	input wire logic                   stack_op,       // stack access
	input wire logic [GPR_W-1:0]       agen_offset,    // effective address
	input wire logic [GPR_W-1:0]       instr_pointer,  // fetch offset in
	input wire logic [GPR_W-1:0]       rd_data_a,      // read data a
	input wire logic                   seg_load_fault, // refused load
	input wire logic [SEL_W-1:0]       fetch_sel,      // code selector
	input wire logic [GPR_W-1:0]       fetch_offset,   // fetch offset out
	input wire logic [SEL_W-1:0]       agen_sel,       // selector in use
	input wire logic [BASE_W-1:0]      lin_addr,       // linear address
	input wire logic                   limit_fault     // limit violation
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	logic lng; // core in 64-bit mode
	logic qw;  // qword operand cycle
	logic dw;  // dword operand cycle
	assign lng = (mode == MODE_LONG);
	assign qw = lng && ext_prefix && size_override && !byte_op && !word_op;
	assign dw = lng && !byte_op && !word_op && !(size_override && ext_prefix);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	// gpr width semantics, checked through a qword read next cycle
	property p_qword_write;
		qw && wr_en ##1 qw && rd_code_a == $past(wr_code)
		|-> rd_data_a == $past(wr_data);
	endproperty
	a_qword_write: assert property (p_qword_write)
		else $error("qword write not stored whole");
	property p_dword_zero;
		dw && wr_en && (ext_prefix || !wr_code[3])
		##1 qw && rd_code_a == $past(wr_code)
		|-> rd_data_a == {32'h0, $past(wr_data[31:0])};
	endproperty
	a_dword_zero: assert property (p_dword_zero)
		else $error("dword write left upper half");
	// needs three cycles: a byte op cannot show the full register
	property p_byte_keep;
		qw && !wr_en
		##1 lng && ext_prefix && byte_op && wr_en
			&& wr_code == $past(rd_code_a)
		##1 qw && rd_code_a == $past(wr_code)
		|-> rd_data_a == {$past(rd_data_a[63:8], 2), $past(wr_data[7:0])};
	endproperty
	a_byte_keep: assert property (p_byte_keep)
		else $error("byte write touched upper bits");
	property p_fetch;
		fetch_offset == instr_pointer;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch offset differs");
	property p_code_guard;
		seg_wr_en && seg_wr_sel == SEG_CODE && !ctl_transfer
		|-> seg_load_fault ##1 $stable(fetch_sel);
	endproperty
	a_code_guard: assert property (p_code_guard)
		else $error("explicit code selector load taken");
	property p_stack_load;
		seg_wr_en && seg_wr_sel == SEG_STACK && seg_wr_data >= 16'h0004
		##1 (stack_op || agen_seg == SEG_STACK)
		|-> agen_sel == $past(seg_wr_data);
	endproperty
	a_stack_load: assert property (p_stack_load)
		else $error("stack selector load lost");
	property p_null_stack;
		seg_wr_en && seg_wr_sel == SEG_STACK && seg_wr_data < 16'h0004
		|-> seg_load_fault;
	endproperty
	a_null_stack: assert property (p_null_stack)
		else $error("null stack selector accepted");
	property p_flat_base;
		lng && !stack_op
		&& agen_seg inside {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA}
		|-> lin_addr == agen_offset;
	endproperty
	a_flat_base: assert property (p_flat_base)
		else $error("flat segment used a base");
	property p_aux_base;
		lng && !stack_op && agen_seg inside {SEG_AUX1, SEG_AUX2}
		|-> lin_addr == desc_base + agen_offset;
	endproperty
	a_aux_base: assert property (p_aux_base)
		else $error("aux segment base dropped");
	property p_no_limit;
		lng |-> !limit_fault;
	endproperty
	a_no_limit: assert property (p_no_limit)
		else $error("limit fault in 64-bit mode");
	// ------------------------------------------------------------
	// covers
	// ------------------------------------------------------------
	c_byte_keep: cover property (p_byte_keep);
	c_code_guard: cover property (seg_wr_en && seg_load_fault);
	c_aux_base: cover property (lng && agen_seg == SEG_AUX1);
endmodule
bind gpr_seg_regfile gpr_seg_regfile_sva chk (.*);
`default_nettype wire

/* bench/pipe_model.sv */
// partner: decode stage issuing gpr requests one cycle after command
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
	input  wire logic        ref_clk,       // core clock
	input  wire logic        resetn,        // async reset, low
	input  wire logic [3:0]  c_f,           // prefix, qword, byte, word
	input  wire logic        c_wr,          // command writes
	input  wire logic [3:0]  c_code,        // command register code
	input  wire logic [63:0] c_data,        // command result
	output logic             ext_prefix,    // extension prefix
	output logic             size_override, // qword request
	output logic             byte_op,       // byte size
	output logic             word_op,       // word size
	output logic             wr_en,         // write request
	output logic [3:0]       wr_code,       // write code
	output logic [63:0]      wr_data,       // write data
	output logic [3:0]       rd_code_a,     // read code a
	output logic [3:0]       rd_code_b      // read code b
);
	// ------------------------------------------------------------
	// issue register
	// ------------------------------------------------------------
	// all operands share one prefix and one code, so code 12..15 without the prefix meets a high byte
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{ext_prefix, size_override, byte_op, word_op, wr_en} <= '0;
			{wr_code, wr_data, rd_code_a, rd_code_b} <= '0;
		end else begin
			ext_prefix <= c_f[3];
			size_override <= c_f[2] & c_f[3];
			{byte_op, word_op, wr_en} <= {c_f[1:0], c_wr};
			{wr_code, wr_data, rd_code_a, rd_code_b} <= {c_code, c_data, c_code, c_code};
		end
	end
endmodule
`default_nettype wire

/* src/gpr_byte_decode.sv */
// byte lane and register index decode for one gpr operand
`timescale 1ns/1ps
`default_nettype none
module gpr_byte_decode
	import regfile_pkg::*;
(
	input  wire logic [3:0]      code,        // encoded register number
	input  wire regfile_pkg::opsize_t size,   // operand size
	input  wire logic            ext_prefix,  // operand extension prefix
	output logic [3:0]           index,       // physical register index
	output logic                 high_byte,   // legacy high byte selected
	output logic [7:0]           byte_en      // per-byte lane enables
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// codes 4..7 without the prefix name the high byte of regs 0..3
	always_comb begin
		index     = code;
		high_byte = 1'b0;
		byte_en   = 8'h00;
		case (size)
			OPSZ_BYTE: begin
				if (!ext_prefix && code[2:0] >= HIGH_BYTE_LO) begin
					index     = {2'b00, code[1:0]};
					high_byte = 1'b1;
					byte_en   = 8'h02;
				end else begin
					byte_en   = 8'h01;
				end
			end
			OPSZ_WORD:  byte_en = 8'h03;
			OPSZ_DWORD: byte_en = 8'h0f;
			OPSZ_QWORD: byte_en = 8'hff;
			default:    byte_en = 8'h00;
		endcase
	end

endmodule
`default_nettype wire

/* src/gpr_seg_regfile.sv */
// gpr and segment selector register file of the core
`timescale 1ns/1ps
`default_nettype none
module gpr_seg_regfile
	import regfile_pkg::*;
(
	input  wire logic                  ref_clk,       // core clock
	input  wire logic                  resetn,        // async reset, low
	input  wire regfile_pkg::cpu_mode_t mode,         // current operating mode
	input  wire logic                  ext_prefix,    // operand extension prefix
	input  wire logic                  size_override, // request qword size
	input  wire logic                  byte_op,       // byte operand
	input  wire logic                  word_op,       // word operand
	input  wire logic [3:0]            rd_code_a,     // read port a code
	input  wire logic [3:0]            rd_code_b,     // read port b code
	input  wire logic                  wr_en,         // write request
	input  wire logic [3:0]            wr_code,       // destination code
	input  wire logic [GPR_W-1:0]      wr_data,       // result, low aligned
	input  wire logic                  seg_wr_en,     // selector load request
	input  wire regfile_pkg::seg_t     seg_wr_sel,    // segment to load
	input  wire logic [SEL_W-1:0]      seg_wr_data,   // selector value
	input  wire logic                  ctl_transfer,  // implicit load by branch
	input  wire logic [BASE_W-1:0]     desc_base,     // descriptor cache base
	input  wire logic [LIMIT_W-1:0]    desc_limit,    // descriptor cache limit
	input  wire regfile_pkg::seg_t     agen_seg,      // segment for data access
	input  wire logic                  stack_op,      // access is a stack op
	input  wire logic [GPR_W-1:0]      agen_offset,   // effective address
	input  wire logic [GPR_W-1:0]      instr_pointer, // next instruction offset
	output logic [GPR_W-1:0]           rd_data_a,     // read data a
	output logic [GPR_W-1:0]           rd_data_b,     // read data b
	output logic                       byte_conflict, // illegal byte mix
	output logic                       prefix_fault,  // size/reg needs prefix
	output logic                       seg_load_fault,// rejected selector load
	output logic [SEL_W-1:0]           fetch_sel,     // code selector for fetch
	output logic [GPR_W-1:0]           fetch_offset,  // fetch offset
	output logic [SEL_W-1:0]           agen_sel,      // selector in use
	output logic [BASE_W-1:0]          lin_addr,      // linear address
	output logic                       limit_fault    // limit violation
);

	// ------------------------------------------------------------
	// operand size and mode decode
	// ------------------------------------------------------------
	opsize_t   size;        // effective operand size
	logic      long_mode;   // 64-bit mode active
	cpu_mode_t mode_q;      // previous mode
	cpu_mode_t mode_d;      // next previous mode
	logic      ext_lost_q;  // extended regs went through legacy mode
	logic      ext_lost_d;  // next value

	assign long_mode = (mode == MODE_LONG);

	// default size is dword; size_override with the prefix in long mode promotes to qword
	always_comb begin
		if (byte_op) begin
			size = OPSZ_BYTE;
		end else if (word_op) begin
			size = OPSZ_WORD;
		end else if (size_override && ext_prefix && long_mode) begin
			size = OPSZ_QWORD;
		end else begin
			size = OPSZ_DWORD;
		end
	end

	// ------------------------------------------------------------
	// decoders for both read ports and the write port
	// ------------------------------------------------------------
	logic [3:0] idx_a, idx_b, idx_w;  // physical indices
	logic       hi_a, hi_b, hi_w;     // high-byte selects
	logic [7:0] be_a, be_b, be_w;     // lane enables
	logic [3:0] code_a, code_b, code_w; // codes with prefix bit masked

	// the top code bit only reaches extended regs with the prefix present
	function automatic logic [3:0] mask_code(input logic [3:0] c,
		input logic pfx);
		mask_code = {c[3] & pfx, c[2:0]};
	endfunction

	assign code_a = mask_code(rd_code_a, ext_prefix);
	assign code_b = mask_code(rd_code_b, ext_prefix);
	assign code_w = mask_code(wr_code, ext_prefix);

	gpr_byte_decode u_dec_a (
		.code       (code_a),
		.size       (size),
		.ext_prefix (ext_prefix),
		.index      (idx_a),
		.high_byte  (hi_a),
		.byte_en    (be_a)
	);

	gpr_byte_decode u_dec_b (
		.code       (code_b),
		.size       (size),
		.ext_prefix (ext_prefix),
		.index      (idx_b),
		.high_byte  (hi_b),
		.byte_en    (be_b)
	);

	gpr_byte_decode u_dec_w (
		.code       (code_w),
		.size       (size),
		.ext_prefix (ext_prefix),
		.index      (idx_w),
		.high_byte  (hi_w),
		.byte_en    (be_w)
	);

	// ------------------------------------------------------------
	// request checks
	// ------------------------------------------------------------
	// a raw code with bit 3 set that still lands on a high byte means the
	// caller mixed a new byte reg with a legacy high byte; the masked
	// decode cannot see that, so the raw codes are checked here
	always_comb begin
		byte_conflict = (size == OPSZ_BYTE) &&
			(hi_a || hi_b || hi_w) &&
			(rd_code_a[3] || rd_code_b[3] || wr_code[3]);
		prefix_fault = ((size_override && long_mode) ||
			wr_code[3] || rd_code_a[3] || rd_code_b[3]) && !ext_prefix;
	end

	// ------------------------------------------------------------
	// gpr storage
	// ------------------------------------------------------------
	logic [GPR_W-1:0] gpr_q [GPR_COUNT]; // register array
	logic [GPR_W-1:0] gpr_d [GPR_COUNT]; // next values
	logic             clear_upper;       // zero bits 63:32 on write
	logic [GPR_W-1:0] wr_shifted;        // result placed in its lanes

	// dword writes zero extend; byte and word writes merge with old bits
	assign clear_upper = (size == OPSZ_DWORD);
	assign wr_shifted  = hi_w ? {wr_data[55:0], 8'h00} : wr_data;

	// mode tracking: note a legacy visit since the last long mode
	always_comb begin
		mode_d     = mode;
		ext_lost_d = ext_lost_q;
		if (mode == MODE_LEGACY) begin
			ext_lost_d = 1'b1;
		end else if (mode == MODE_LONG) begin
			ext_lost_d = 1'b0;
		end
	end

	// write merge per byte lane; upper half cleared on dword writes
	generate
		for (genvar r = 0; r < GPR_COUNT; r++) begin : g_gpr
			always_comb begin
				gpr_d[r] = gpr_q[r];
				// leaving long mode drops upper halves (allowed, chosen)
				if (mode_q == MODE_LONG && mode != MODE_LONG) begin
					gpr_d[r][63:32] = 32'h0000_0000;
				end
				// extended regs cleared on legacy return; they survive compat
				if (r >= GPR_FIRST_EXT && ext_lost_q && long_mode) begin
					gpr_d[r] = GPR_RESET;
				end
				if (wr_en && idx_w == 4'(r)) begin
					for (int b = 0; b < 8; b++) begin
						if (be_w[b]) begin
							gpr_d[r][b*8 +: 8] = wr_shifted[b*8 +: 8];
						end
					end
					if (clear_upper) begin
						gpr_d[r][63:32] = 32'h0000_0000;
					end
				end
			end
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					gpr_q[r] <= GPR_RESET;
				end else begin
					gpr_q[r] <= gpr_d[r];
				end
			end
		end
	endgenerate

	// mode memory; reset takes the core as already in 64-bit mode,
	// so the first exit from it clears the upper halves as usual
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_q     <= MODE_LONG;
			ext_lost_q <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			ext_lost_q <= ext_lost_d;
		end
	end

	// ------------------------------------------------------------
	// read ports
	// ------------------------------------------------------------
	// extract the lanes; a high byte read shifts down by 8 and keeps lane 15:8, so it returns bits 23:16 there
	function automatic logic [GPR_W-1:0] rd_extract(
		input logic [GPR_W-1:0] v, input logic hi, input logic [7:0] be);
		logic [GPR_W-1:0] s;
		s = hi ? {8'h00, v[63:8]} : v;
		for (int b = 0; b < 8; b++) begin
			if (!be[b]) begin
				s[b*8 +: 8] = 8'h00;
			end
		end
		rd_extract = s;
	endfunction

	// both ports read the stored array, so a write shows a cycle later
	always_comb begin
		rd_data_a = rd_extract(gpr_q[idx_a], hi_a, be_a);
		rd_data_b = rd_extract(gpr_q[idx_b], hi_b, be_b);
	end

	// ------------------------------------------------------------
	// segment selectors
	// ------------------------------------------------------------
	logic [SEL_W-1:0] sel_q [SEG_COUNT]; // six selectors
	logic [SEL_W-1:0] sel_d [SEG_COUNT]; // next values
	logic             load_ok;           // load passes checks

	// a null selector in the code or stack register is refused even in
	// long mode, since compat code may later run on it
	always_comb begin
		load_ok = 1'b1;
		if ((seg_wr_sel == SEG_CODE || seg_wr_sel == SEG_STACK) &&
			seg_wr_data[SEL_W-1:2] == '0) begin
			load_ok = 1'b0;
		end
		if (seg_wr_sel == SEG_CODE && !ctl_transfer) begin
			load_ok = 1'b0;
		end
		if (int'(seg_wr_sel) >= SEG_COUNT) begin
			load_ok = 1'b0;
		end
	end

	// a refused load leaves the selector as it was
	generate
		for (genvar s = 0; s < SEG_COUNT; s++) begin : g_sel
			always_comb begin
				sel_d[s] = sel_q[s];
				if (seg_wr_en && load_ok && int'(seg_wr_sel) == s) begin
					sel_d[s] = seg_wr_data;
				end
			end
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					sel_q[s] <= SEL_RESET;
				end else begin
					sel_q[s] <= sel_d[s];
				end
			end
		end
	endgenerate

	// fault reported in the same cycle as the refused request
	assign seg_load_fault = seg_wr_en && !load_ok;

	// ------------------------------------------------------------
	// fetch and data address generation
	// ------------------------------------------------------------
	seg_t eff_seg; // stack ops always go through the stack selector

	assign eff_seg      = stack_op ? SEG_STACK : agen_seg;
	assign fetch_sel    = sel_q[SEG_CODE];
	assign fetch_offset = instr_pointer;
	assign agen_sel     = sel_q[eff_seg];

	seg_addr_gen u_agen (
		.long_mode   (long_mode),
		.seg         (eff_seg),
		.desc_base   (desc_base),
		.desc_limit  (desc_limit),
		.offset      (agen_offset),
		.lin_addr    (lin_addr),
		.limit_fault (limit_fault)
	);

endmodule
`default_nettype wire

/* src/regfile_pkg.sv */
// package: constants and types for the gpr and segment register file
`default_nettype none
package regfile_pkg;

	// ------------------------------------------------------------
	// widths and counts
	// ------------------------------------------------------------
	localparam int GPR_COUNT    = 16;      // sixteen gprs in 64-bit mode
	localparam int GPR_W        = 64;      // full register width
	localparam int SEG_COUNT    = 6;       // six segment selectors
	localparam int SEL_W        = 16;      // selector width
	localparam int BASE_W       = 64;      // segment base width
	localparam int LIMIT_W      = 32;      // segment limit width

	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [3:0] GPR_ACCUM = 4'h0; // accumulator class start
	localparam logic [3:0] GPR_SP    = 4'h4; // stack pointer
	localparam logic [3:0] GPR_FIRST_EXT = 4'h8; // first extended gpr

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [GPR_W-1:0]  GPR_RESET  = 64'h0000_0000_0000_0000;
	localparam logic [SEL_W-1:0]  SEL_RESET  = 16'h0000;
	localparam logic [BASE_W-1:0] BASE_RESET = 64'h0000_0000_0000_0000;
	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 32'hffff_ffff;
	localparam logic [BASE_W-1:0] FLAT_BASE  = 64'h0000_0000_0000_0000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OPSZ_BYTE  = 2'h0,
		OPSZ_WORD  = 2'h1,
		OPSZ_DWORD = 2'h2,
		OPSZ_QWORD = 2'h3
	} opsize_t;

	typedef enum logic [2:0] {
		SEG_EXTRA = 3'h0,
		SEG_CODE  = 3'h1,
		SEG_STACK = 3'h2,
		SEG_DATA  = 3'h3,
		SEG_AUX1  = 3'h4,
		SEG_AUX2  = 3'h5
	} seg_t;

	// gray-coded operating modes along long -> compat -> legacy path
	typedef enum logic [1:0] {
		MODE_LONG   = 2'h0,
		MODE_COMPAT = 2'h1,
		MODE_LEGACY = 2'h3
	} cpu_mode_t;

	// ------------------------------------------------------------
	// legality of a byte-register request
	// ------------------------------------------------------------
	localparam logic [2:0] HIGH_BYTE_LO = 3'h4; // codes 4..7 are special

endpackage
`default_nettype wire

/* src/seg_addr_gen.sv */
// segment base and limit selection for address generation
`timescale 1ns/1ps
`default_nettype none
module seg_addr_gen
	import regfile_pkg::*;
(
	input  wire logic                long_mode,  // core is in 64-bit mode
	input  wire regfile_pkg::seg_t   seg,        // segment in use
	input  wire logic [BASE_W-1:0]   desc_base,  // base from descriptor cache
	input  wire logic [LIMIT_W-1:0]  desc_limit, // limit from descriptor cache
	input  wire logic [GPR_W-1:0]    offset,     // effective address
	output logic [BASE_W-1:0]        lin_addr,   // linear address
	output logic                     limit_fault // offset beyond limit
);

	// ------------------------------------------------------------
	// base select and limit check
	// ------------------------------------------------------------
	// the two aux segments keep their base in 64-bit mode, the rest go flat
	always_comb begin
		logic [BASE_W-1:0] base;
		base = desc_base;
		if (long_mode && seg != SEG_AUX1 && seg != SEG_AUX2) begin
			base = FLAT_BASE;
		end
		lin_addr    = base + offset;
		limit_fault = 1'b0;
		if (!long_mode) begin
			limit_fault = (offset[GPR_W-1:LIMIT_W] != '0) ||
				(offset[LIMIT_W-1:0] > desc_limit);
		end
	end

endmodule
`default_nettype wire
